/* File: flrc_loop.sv */
// One frequency-locked loop: reference select, pre-divide, digital
// oscillator with tracking or forced code, and bypass output.
// Assumes all clock level inputs are already synchronised.
`timescale 1ns/1ps
module flrc_loop (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_ref_lvl,
  input wire logic i_byp_lvl,
  input wire logic i_enable,
  input wire logic i_osc_enable,
  input wire logic i_bypass,
  input wire logic i_forced_sel,
  input wire logic [flrc_pkg::CODE_W-1:0] i_forced_code,
  input wire logic [1:0] i_prediv,
  input wire logic [1:0] i_source,
  output logic o_clk,
  output logic o_ref_tick,
  output logic [flrc_pkg::CODE_W-1:0] o_osc_code,
  output logic o_running
);
  import flrc_pkg::*;

  logic sel_lvl;
  logic prev_reg;
  logic sel_edge;
  logic [2:0] div_cnt_reg;
  logic [2:0] div_limit;
  logic tick_now;
  logic [ACC_W-1:0] acc_reg;
  logic msb_prev_reg;
  logic [1:0] nco_cnt_reg;
  logic running;

  assign sel_lvl = i_ref_lvl[i_source];
  assign sel_edge = sel_lvl & ~prev_reg;
  // Codes 0..3 give divide by 1, 2, 4, 8
  assign div_limit = 3'((4'h1 << i_prediv) - 4'h1);
  assign tick_now = i_enable & sel_edge & (div_cnt_reg >= div_limit);
  // Free-run needs the oscillator enable with forced control
  assign running = i_enable | (i_osc_enable & i_forced_sel);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= sel_lvl;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_cnt_reg <= 3'h0;
      o_ref_tick <= 1'b0;
    end else begin
      o_ref_tick <= tick_now;
      if (!i_enable || tick_now) begin
        div_cnt_reg <= 3'h0;
      end else if (sel_edge) begin
        div_cnt_reg <= div_cnt_reg + 3'h1;
      end
    end
  end

  // Oscillator; a stopped reference just freezes the code
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc_reg <= '0;
      msb_prev_reg <= 1'b0;
      o_running <= 1'b0;
    end else begin
      o_running <= running;
      msb_prev_reg <= acc_reg[ACC_W-1];
      if (!running) begin
        acc_reg <= '0;
      end else begin
        acc_reg <= acc_reg + ACC_W'(o_osc_code);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_osc_code <= FORCED_CODE_RST;
      nco_cnt_reg <= 2'h0;
    end else if (i_forced_sel) begin
      o_osc_code <= i_forced_code;
      nco_cnt_reg <= 2'h0;
    end else if (tick_now) begin
      nco_cnt_reg <= 2'h0;
      // Step toward one oscillator cycle per reference tick
      if (nco_cnt_reg == 2'h0 && o_osc_code != '1) begin
        o_osc_code <= o_osc_code + 6'h01;
      end else if (nco_cnt_reg > 2'h1 && o_osc_code != '0) begin
        o_osc_code <= o_osc_code - 6'h01;
      end
    end else if (acc_reg[ACC_W-1] && !msb_prev_reg && nco_cnt_reg != 2'h3) begin
      nco_cnt_reg <= nco_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_clk <= 1'b0;
    end else if (i_bypass) begin
      o_clk <= i_byp_lvl;
    end else begin
      o_clk <= acc_reg[ACC_W-1];
    end
  end
endmodule : flrc_loop

/* File: flrc_pkg.sv */
// Constants for the loop reference and free-run control block.
// Assumes a 10-bit register index bus with 16-bit data.
package flrc_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int CODE_W = 6;
  localparam int ACC_W = 8;

  // Register indices
  localparam logic [9:0] LOOP1_CTRL_ONE_ADDR = 10'h220;
  localparam logic [9:0] LOOP1_CTRL_FIVE_ADDR = 10'h224;
  localparam logic [9:0] LOOP1_STATUS_ADDR = 10'h228;
  localparam logic [9:0] LOOP2_CTRL_ONE_ADDR = 10'h240;
  localparam logic [9:0] LOOP2_CTRL_FIVE_ADDR = 10'h244;
  localparam logic [9:0] LOOP2_FRAC_DENOM_ADDR = 10'h246;
  localparam logic [9:0] LOOP2_FRAC_MODE_ADDR = 10'h247;
  localparam logic [9:0] LOOP2_STATUS_ADDR = 10'h248;

  // Control one fields
  localparam int ENABLE_BIT = 0;
  localparam int OSC_ENABLE_BIT = 1;
  // Control five fields
  localparam int BYPASS_BIT = 15;
  localparam int CODE_MSB = 12;
  localparam int CODE_LSB = 7;
  localparam int FORCED_BIT = 6;
  localparam int PREDIV_MSB = 4;
  localparam int PREDIV_LSB = 3;
  localparam int SOURCE_MSB = 1;
  localparam int SOURCE_LSB = 0;
  // Fraction mode fields
  localparam int FRAC_EN_BIT = 0;
  localparam int FRAC_RSV_MSB = 2;
  localparam int FRAC_RSV_LSB = 1;
  // Status fields
  localparam int STAT_RUN_BIT = 8;

  // Reset values
  localparam logic [5:0] FORCED_CODE_RST = 6'h19;
  localparam logic [1:0] FRAC_RSV_VAL = 2'h3;
  localparam logic [15:0] FRAC_DENOM_RST = 16'h0000;
  localparam logic [1:0] PREDIV_RST = 2'h0;
  localparam logic [1:0] SOURCE_RST = 2'h0;

  // Reference source codes
  typedef enum logic [1:0] {
    FLRC_SRC_MCLK_ONE = 2'h0,
    FLRC_SRC_MCLK_TWO = 2'h1,
    FLRC_SRC_FRAME = 2'h2,
    FLRC_SRC_BIT = 2'h3
  } flrc_src_t;

  // Pin synchroniser slots
  localparam int PIN_MASTER_CLOCK_ONE = 0;
  localparam int PIN_MASTER_CLOCK_TWO = 1;
  localparam int PIN_FCLK1 = 2;
  localparam int PIN_BCLK1 = 3;
  localparam int PIN_FCLK2 = 4;
  localparam int PIN_BIT_CLOCK_TWO = 5;
  localparam int PIN_N = 6;
endpackage : flrc_pkg

/* File: flrc_ref_src.sv */
// Reference clock sources for the loop block: six pins, one running
// at a time, each standing low while stopped.
// Assumes it shares the control clock and reset of the bench.
`timescale 1ns/1ps
module flrc_ref_src #(
  parameter int HALF = 3
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [5:0] i_run,
  output logic [5:0] o_pins
);
  logic [7:0] cnt_reg;
  logic lvl_reg;

  // Slow enough that the divided reference never exceeds the limit
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= 8'h00;
      lvl_reg <= 1'b0;
    end else if (i_run == 6'h00) begin
      cnt_reg <= 8'h00;
      lvl_reg <= 1'b0;
    end else if (cnt_reg == 8'(HALF - 1)) begin
      cnt_reg <= 8'h00;
      lvl_reg <= ~lvl_reg;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // Stopped pins stand low, so no stale edge leaks into a count
  assign o_pins = i_run & {6{lvl_reg}};
endmodule : flrc_ref_src

/* File: flrc_top.sv */
// Register file and pin front end for two frequency-locked loops.
// Assumes a single-cycle register port and free-running reference pins.
// Overview of operation
// - Loop two bypass takes its output from bit clock two directly.
// - Pre-divider codes 00..11 divide the reference by 1, 2, 4, 8.
// - Loop two source codes pick master one, master two, frame two, bit two.
// - Sixteen-bit denominator register, plain integer, resets to zero.
// - Fractional-mode bit: clear is integer, set is fractional; resets clear.
// - A running loop keeps a steady output after its reference stops.
// - Each loop has an oscillator enable at bit 1, reset clear.
// - Forced-control select at bit 6 makes the oscillator follow the code.
// - Six-bit forced code in bits 12:7, any value, resets to 19h.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module flrc_top (
  input wire logic I_REF_CLK,
  input wire logic I_RST_B,
  input wire logic [flrc_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [flrc_pkg::DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [flrc_pkg::DATA_W-1:0] O_RDATA,
  input wire logic I_MASTER_CLOCK_ONE,
  input wire logic I_MASTER_CLOCK_TWO,
  input wire logic I_FRAME_CLOCK_ONE,
  input wire logic I_BIT_CLOCK_ONE,
  input wire logic I_FRAME_CLOCK_TWO,
  input wire logic I_BIT_CLOCK_TWO,
  output logic O_LOOP1_CLK,
  output logic O_LOOP2_CLK,
  output logic O_LOOP1_REF_TICK,
  output logic O_LOOP2_REF_TICK,
  output logic [flrc_pkg::CODE_W-1:0] O_LOOP1_OSC_CODE,
  output logic [flrc_pkg::CODE_W-1:0] O_LOOP2_OSC_CODE,
  output logic O_LOOP2_FRAC_MODE,
  output logic [flrc_pkg::DATA_W-1:0] O_LOOP2_FRAC_DENOM
);
  import flrc_pkg::*;

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] sync1_reg;
  logic [PIN_N-1:0] sync2_reg;
  logic [1:0][DATA_W-1:0] loop_rdata;
  logic [1:0] loop_hit;
  logic [1:0] loop_clk;
  logic [1:0] loop_tick;
  logic [1:0][CODE_W-1:0] loop_code;
  logic [1:0] loop_run;
  logic [1:0] loop_en;
  logic [1:0] loop_forced;
  logic [1:0] loop_bypass;
  logic [1:0] loop_osc_en;
  logic [1:0][CODE_W-1:0] loop_fcode;
  logic [1:0][1:0] loop_prediv;
  logic [1:0][1:0] loop_source;
  logic [DATA_W-1:0] rdata_next;

  assign pin_raw = {I_BIT_CLOCK_TWO, I_FRAME_CLOCK_TWO, I_BIT_CLOCK_ONE,
                    I_FRAME_CLOCK_ONE, I_MASTER_CLOCK_TWO,
                    I_MASTER_CLOCK_ONE};

  // Reference pins are asynchronous to the control clock
  genvar gp;
  generate
    for (gp = 0; gp < PIN_N; gp++) begin : g_sync
      always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
          sync1_reg[gp] <= 1'b0;
          sync2_reg[gp] <= 1'b0;
        end else begin
          sync1_reg[gp] <= pin_raw[gp];
          sync2_reg[gp] <= sync1_reg[gp];
        end
      end
    end
  endgenerate

  // Both loops share one structure; only bases and pins differ
  genvar gl;
  generate
    for (gl = 0; gl < 2; gl++) begin : g_loop
      localparam logic [9:0] ONE_A = (gl == 0) ? LOOP1_CTRL_ONE_ADDR
                                               : LOOP2_CTRL_ONE_ADDR;
      localparam logic [9:0] FIVE_A = (gl == 0) ? LOOP1_CTRL_FIVE_ADDR
                                                : LOOP2_CTRL_FIVE_ADDR;
      localparam logic [9:0] STAT_A = (gl == 0) ? LOOP1_STATUS_ADDR
                                                : LOOP2_STATUS_ADDR;
      localparam int FRM = (gl == 0) ? PIN_FCLK1 : PIN_FCLK2;
      localparam int BIT = (gl == 0) ? PIN_BCLK1 : PIN_BIT_CLOCK_TWO;
      logic enable_reg;
      logic osc_en_reg;
      logic bypass_reg;
      logic forced_reg;
      logic [CODE_W-1:0] fcode_reg;
      logic [1:0] prediv_reg;
      logic [1:0] source_reg;
      logic [3:0] cand;
      logic [DATA_W-1:0] rdata_loc;
      logic hit_loc;

      assign cand = {sync2_reg[BIT], sync2_reg[FRM], sync2_reg[PIN_MASTER_CLOCK_TWO],
                     sync2_reg[PIN_MASTER_CLOCK_ONE]};

      always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
          enable_reg <= 1'b0;
          osc_en_reg <= 1'b0;
        end else if (I_WR && I_ADDR == ONE_A) begin
          enable_reg <= I_WDATA[ENABLE_BIT];
          osc_en_reg <= I_WDATA[OSC_ENABLE_BIT];
        end
      end

      always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
          bypass_reg <= 1'b0;
          forced_reg <= 1'b0;
          fcode_reg <= FORCED_CODE_RST;
          prediv_reg <= PREDIV_RST;
          source_reg <= SOURCE_RST;
        end else if (I_WR && I_ADDR == FIVE_A) begin
          bypass_reg <= I_WDATA[BYPASS_BIT];
          forced_reg <= I_WDATA[FORCED_BIT];
          fcode_reg <= I_WDATA[CODE_MSB:CODE_LSB];
          prediv_reg <= I_WDATA[PREDIV_MSB:PREDIV_LSB];
          source_reg <= I_WDATA[SOURCE_MSB:SOURCE_LSB];
        end
      end

      // Local result per loop, so each shared vector has one writer per bit
      always_comb begin
        rdata_loc = '0;
        hit_loc = 1'b1;
        if (I_ADDR == ONE_A) begin
          rdata_loc[ENABLE_BIT] = enable_reg;
          rdata_loc[OSC_ENABLE_BIT] = osc_en_reg;
        end else if (I_ADDR == FIVE_A) begin
          rdata_loc[BYPASS_BIT] = bypass_reg;
          rdata_loc[CODE_MSB:CODE_LSB] = fcode_reg;
          rdata_loc[FORCED_BIT] = forced_reg;
          rdata_loc[PREDIV_MSB:PREDIV_LSB] = prediv_reg;
          rdata_loc[SOURCE_MSB:SOURCE_LSB] = source_reg;
        end else if (I_ADDR == STAT_A) begin
          rdata_loc[STAT_RUN_BIT] = loop_run[gl];
          rdata_loc[CODE_W-1:0] = loop_code[gl];
        end else begin
          hit_loc = 1'b0;
        end
      end

      assign loop_rdata[gl] = rdata_loc;
      assign loop_hit[gl] = hit_loc;
      assign loop_en[gl] = enable_reg;
      assign loop_forced[gl] = forced_reg;
      assign loop_bypass[gl] = bypass_reg;
      assign loop_osc_en[gl] = osc_en_reg;
      assign loop_fcode[gl] = fcode_reg;
      assign loop_prediv[gl] = prediv_reg;
      assign loop_source[gl] = source_reg;

      flrc_loop flrc_loop_inst (
        .i_clk(I_REF_CLK),
        .i_rst_b(I_RST_B),
        .i_ref_lvl(cand),
        .i_byp_lvl(sync2_reg[BIT]),
        .i_enable(enable_reg),
        .i_osc_enable(osc_en_reg),
        .i_bypass(bypass_reg),
        .i_forced_sel(forced_reg),
        .i_forced_code(fcode_reg),
        .i_prediv(prediv_reg),
        .i_source(source_reg),
        .o_clk(loop_clk[gl]),
        .o_ref_tick(loop_tick[gl]),
        .o_osc_code(loop_code[gl]),
        .o_running(loop_run[gl])
      );
    end
  endgenerate

  assign O_LOOP1_CLK = loop_clk[0];
  assign O_LOOP2_CLK = loop_clk[1];
  assign O_LOOP1_REF_TICK = loop_tick[0];
  assign O_LOOP2_REF_TICK = loop_tick[1];
  assign O_LOOP1_OSC_CODE = loop_code[0];
  assign O_LOOP2_OSC_CODE = loop_code[1];

  // Fractional controls of loop two
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_LOOP2_FRAC_DENOM <= FRAC_DENOM_RST;
    end else if (I_WR && I_ADDR == LOOP2_FRAC_DENOM_ADDR) begin
      O_LOOP2_FRAC_DENOM <= I_WDATA;
    end
  end

  // Reserved bits ignore writes and always read back as 11
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_LOOP2_FRAC_MODE <= 1'b0;
    end else if (I_WR && I_ADDR == LOOP2_FRAC_MODE_ADDR) begin
      O_LOOP2_FRAC_MODE <= I_WDATA[FRAC_EN_BIT];
    end
  end

  always_comb begin
    rdata_next = '0;
    if (I_ADDR == LOOP2_FRAC_DENOM_ADDR) begin
      rdata_next = O_LOOP2_FRAC_DENOM;
    end else if (I_ADDR == LOOP2_FRAC_MODE_ADDR) begin
      rdata_next[FRAC_RSV_MSB:FRAC_RSV_LSB] = FRAC_RSV_VAL;
      rdata_next[FRAC_EN_BIT] = O_LOOP2_FRAC_MODE;
    end else if (loop_hit[0]) begin
      rdata_next = loop_rdata[0];
    end else if (loop_hit[1]) begin
      rdata_next = loop_rdata[1];
    end
  end

  // Data valid only in the cycle after the read strobe
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_RDATA <= '0;
    end else if (I_RD) begin
      O_RDATA <= rdata_next;
    end else begin
      O_RDATA <= '0;
    end
  end

  // Helpers watching the same synced levels as the loops
  logic [1:0] ref2_prev_reg;
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ref2_prev_reg <= 2'h0;
    end else begin
      ref2_prev_reg <= {sync2_reg[PIN_BIT_CLOCK_TWO], sync2_reg[PIN_FCLK2]};
    end
  end

  logic [2:0] pin_prev_reg;
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pin_prev_reg <= 3'h0;
    end else begin
      pin_prev_reg <= {sync2_reg[PIN_BCLK1], sync2_reg[PIN_MASTER_CLOCK_TWO],
                       sync2_reg[PIN_MASTER_CLOCK_ONE]};
    end
  end

  bypass_out_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    $past(loop_bypass[1]) |-> O_LOOP2_CLK == $past(sync2_reg[PIN_BIT_CLOCK_TWO]))
    else $error("loop two bypass output not following bit clock");

  prediv_one_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (loop_en[1] && loop_prediv[1] == 2'h0 && loop_source[1] == 2'h3 &&
     sync2_reg[PIN_BIT_CLOCK_TWO] && !ref2_prev_reg[1] && $stable(loop_source[1]))
    |=> O_LOOP2_REF_TICK)
    else $error("undivided reference edge gave no tick");

  prediv_eight_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (O_LOOP2_REF_TICK && loop_prediv[1] == 2'h3 && $stable(loop_prediv[1]))
    |=> !O_LOOP2_REF_TICK [*8])
    else $error("divide by eight ticks too close");

  source_frame_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (loop_en[1] && loop_prediv[1] == 2'h0 && loop_source[1] == 2'h2 &&
     sync2_reg[PIN_FCLK2] && !ref2_prev_reg[0] && $stable(loop_source[1]))
    |=> O_LOOP2_REF_TICK)
    else $error("frame clock two edge not used as reference");

  denom_write_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (I_WR && I_ADDR == LOOP2_FRAC_DENOM_ADDR)
    |=> O_LOOP2_FRAC_DENOM == $past(I_WDATA))
    else $error("denominator write not stored");

  frac_mode_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (I_RD && I_ADDR == LOOP2_FRAC_MODE_ADDR)
    |=> O_RDATA == {13'h0000, FRAC_RSV_VAL, $past(O_LOOP2_FRAC_MODE)})
    else $error("fraction mode readback wrong");

  code_hold_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (!loop_forced[1] && !$past(loop_forced[1]) && !O_LOOP2_REF_TICK)
    |-> $stable(O_LOOP2_OSC_CODE))
    else $error("oscillator code moved without a reference tick");

  forced_code_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    $past(loop_forced[0]) |-> O_LOOP1_OSC_CODE == $past(loop_fcode[0]))
    else $error("forced code not applied to loop one");

  osc_off_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (!loop_bypass[1] && !loop_en[1] && !loop_osc_en[1]) [*3]
    |-> !O_LOOP2_CLK)
    else $error("loop two oscillator runs while disabled");

  code_read_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (I_RD && I_ADDR == LOOP1_CTRL_FIVE_ADDR)
    |=> O_RDATA[CODE_MSB:CODE_LSB] == $past(loop_fcode[0]))
    else $error("forced code field readback wrong");

  frac_write_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (I_WR && I_ADDR == LOOP2_FRAC_MODE_ADDR)
    |=> O_LOOP2_FRAC_MODE == $past(I_WDATA[FRAC_EN_BIT]))
    else $error("fractional mode write not stored");

  osc_en_read_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (I_RD && I_ADDR == LOOP2_CTRL_ONE_ADDR)
    |=> O_RDATA[OSC_ENABLE_BIT] == $past(loop_osc_en[1]))
    else $error("oscillator enable readback wrong");

  forced_two_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    $past(loop_forced[1]) |-> O_LOOP2_OSC_CODE == $past(loop_fcode[1]))
    else $error("forced code not applied to loop two");

  mclk_one_src_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (loop_en[1] && loop_prediv[1] == 2'h0 && loop_source[1] == 2'h0 &&
     sync2_reg[PIN_MASTER_CLOCK_ONE] && !pin_prev_reg[0] && $stable(loop_source[1]))
    |=> O_LOOP2_REF_TICK)
    else $error("master clock one edge not used as reference");

  mclk_two_src_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (loop_en[1] && loop_prediv[1] == 2'h0 && loop_source[1] == 2'h1 &&
     sync2_reg[PIN_MASTER_CLOCK_TWO] && !pin_prev_reg[1] && $stable(loop_source[1]))
    |=> O_LOOP2_REF_TICK)
    else $error("master clock two edge not used as reference");

  loop1_bit_src_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (loop_en[0] && loop_prediv[0] == 2'h0 && loop_source[0] == 2'h3 &&
     sync2_reg[PIN_BCLK1] && !pin_prev_reg[2] && $stable(loop_source[0]))
    |=> O_LOOP1_REF_TICK)
    else $error("loop one not using bit clock one");

  prediv_two_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (O_LOOP2_REF_TICK && loop_prediv[1] == 2'h1 && $stable(loop_prediv[1]))
    |=> !O_LOOP2_REF_TICK [*3])
    else $error("divide by two ticks too close");

  tick_gate_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    !loop_en[1] |=> !O_LOOP2_REF_TICK)
    else $error("tick while loop two disabled");
endmodule : flrc_top

/* File: flrc_top_tb.sv */
// Self-checking bench for the two-loop reference and free-run block.
// Assumes the reference source model drives all six clock pins.
`timescale 1ns/1ps
module flrc_top_tb;
  import flrc_pkg::*;
  typedef struct {
    logic [9:0] a;
    logic [15:0] w;
    logic [15:0] r;
  } flrc_row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [5:0] run = 6'h00;
  wire [5:0] pins;
  logic [15:0] rdata, denom, d;
  logic [5:0] code1, code2;
  logic frac, clk1, clk2, tick1, tick2, p1, p2;
  int err_total = 0, checks_done = 0, cyc = 0;
  int t1 = 0, t2 = 0, r1 = 0, r2 = 0;
  logic [5:0] codes [3] = '{6'h19, 6'h3F, 6'h01};
  int pin2 [4] = '{PIN_MASTER_CLOCK_ONE, PIN_MASTER_CLOCK_TWO, PIN_FCLK2, PIN_BIT_CLOCK_TWO};
  flrc_row_t rv [6] = '{
    '{LOOP1_CTRL_ONE_ADDR, 16'h0000, 16'h0000},
    '{LOOP1_CTRL_FIVE_ADDR, 16'h0000, 16'h0C80},
    '{LOOP2_CTRL_ONE_ADDR, 16'h0000, 16'h0000},
    '{LOOP2_CTRL_FIVE_ADDR, 16'h0000, 16'h0C80},
    '{LOOP2_FRAC_DENOM_ADDR, 16'h0000, 16'h0000},
    '{LOOP2_FRAC_MODE_ADDR, 16'h0000, 16'h0006}};
  // Reserved pair always written as 11; last row leaves fractional mode on
  flrc_row_t rows [8] = '{
    '{LOOP2_FRAC_DENOM_ADDR, 16'hA5C3, 16'hA5C3},
    '{LOOP2_FRAC_MODE_ADDR, 16'h0007, 16'h0007},
    '{LOOP2_FRAC_MODE_ADDR, 16'h0006, 16'h0006},
    '{LOOP2_CTRL_FIVE_ADDR, 16'hFFFF, 16'h9FDB},
    '{LOOP1_CTRL_FIVE_ADDR, 16'h7FFF, 16'h1FDB},
    '{LOOP1_CTRL_ONE_ADDR, 16'hFFFE, 16'h0002},
    '{10'h300, 16'hFFFF, 16'h0000},
    '{LOOP2_FRAC_MODE_ADDR, 16'h0007, 16'h0007}};

  always #25 clk = ~clk;

  flrc_ref_src flrc_ref_src_inst (
    .i_clk(clk), .i_rst_b(rst_b), .i_run(run), .o_pins(pins));

  flrc_top flrc_top_inst (
    .I_REF_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_MASTER_CLOCK_ONE(pins[PIN_MASTER_CLOCK_ONE]),
    .I_MASTER_CLOCK_TWO(pins[PIN_MASTER_CLOCK_TWO]),
    .I_FRAME_CLOCK_ONE(pins[PIN_FCLK1]), .I_BIT_CLOCK_ONE(pins[PIN_BCLK1]),
    .I_FRAME_CLOCK_TWO(pins[PIN_FCLK2]), .I_BIT_CLOCK_TWO(pins[PIN_BIT_CLOCK_TWO]),
    .O_LOOP1_CLK(clk1), .O_LOOP2_CLK(clk2), .O_LOOP1_REF_TICK(tick1),
    .O_LOOP2_REF_TICK(tick2), .O_LOOP1_OSC_CODE(code1),
    .O_LOOP2_OSC_CODE(code2), .O_LOOP2_FRAC_MODE(frac),
    .O_LOOP2_FRAC_DENOM(denom));

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string n, input logic [15:0] s,
                     input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr_reg(input logic [9:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [9:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk($sformatf("register %h", a), rdata, e);
  endtask : rd_chk

  // Whole periods only, so the edge count is exact
  task automatic ref_run(input int pin, input int n);
    @(posedge clk);
    #1 t1 = 0;
    t2 = 0;
    r2 = 0;
    run = 6'h01 << pin;
    repeat (6 * n) @(posedge clk);
    #1 run = 6'h00;
    repeat (12) @(posedge clk);
  endtask : ref_run

  task automatic win(input int n);
    repeat (6) @(posedge clk);
    #1 r1 = 0;
    r2 = 0;
    repeat (n) @(posedge clk);
    #1;
  endtask : win

  task automatic reset_chk();
    foreach (rv[i]) rd_chk(rv[i].a, rv[i].r);
    chk("loop1 code", 16'(code1), 16'h0019);
    chk("loop2 code", 16'(code2), 16'h0019);
    chk("frac mode", 16'(frac), 16'h0000);
    chk("denominator", denom, 16'h0000);
  endtask : reset_chk

  always @(posedge clk) begin
    cyc++;
    if (tick1 === 1'b1) t1++;
    if (tick2 === 1'b1) t2++;
    if (clk1 === 1'b1 && p1 === 1'b0) r1++;
    if (clk2 === 1'b1 && p2 === 1'b0) r2++;
    p1 = clk1;
    p2 = clk2;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    reset_chk();
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].w);
      rd_chk(rows[i].a, rows[i].r);
    end
    @(posedge clk);
    #1 chk("idle read data", rdata, 16'h0000);
    chk("frac mode", 16'(frac), 16'h0001);
    chk("denominator", denom, 16'hA5C3);
    // Forced oscillator: stopped without its enable, then each code
    wr_reg(LOOP1_CTRL_ONE_ADDR, 16'h0000);
    wr_reg(LOOP1_CTRL_FIVE_ADDR, 16'h0CC0);
    win(64);
    chk("stopped clock", 16'(r1), 16'h0000);
    // Interface rate settings for the system clock are kept valid upstream
    wr_reg(LOOP1_CTRL_ONE_ADDR, 16'h0002);
    foreach (codes[i]) begin
      wr_reg(LOOP1_CTRL_FIVE_ADDR, 16'({codes[i], 7'h40}));
      win(256);
      chk("forced code", 16'(code1), 16'(codes[i]));
      chk("forced rises", 16'(r1), 16'(codes[i]));
    end
    // Loop one listens on bit clock one only
    wr_reg(LOOP1_CTRL_FIVE_ADDR, 16'h0003);
    wr_reg(LOOP1_CTRL_ONE_ADDR, 16'h0001);
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 4; p++) begin
        wr_reg(LOOP2_CTRL_FIVE_ADDR, 16'((p << 3) | s));
        wr_reg(LOOP2_CTRL_ONE_ADDR, 16'h0001);
        ref_run(pin2[s], 16);
        chk("loop2 ticks", 16'(t2), 16'(16 >> p));
        chk("loop1 ticks", 16'(t1), 16'h0000);
        wr_reg(LOOP2_CTRL_ONE_ADDR, 16'h0000);
      end
    end
    for (int e = 1; e >= 0; e--) begin
      wr_reg(LOOP1_CTRL_ONE_ADDR, 16'(e));
      ref_run(PIN_BCLK1, 8);
      chk("loop1 ticks", 16'(t1), 16'(8 * e));
      chk("loop2 ticks", 16'(t2), 16'h0000);
    end
    wr_reg(LOOP2_CTRL_FIVE_ADDR, 16'h8000);
    ref_run(PIN_BIT_CLOCK_TWO, 16);
    chk("bypass rises", 16'(r2), 16'h0010);
    chk("bypass ticks", 16'(t2), 16'h0000);
    wr_reg(LOOP2_CTRL_FIVE_ADDR, 16'h0000);
    wr_reg(LOOP2_CTRL_ONE_ADDR, 16'h0001);
    ref_run(PIN_MASTER_CLOCK_ONE, 20);
    d = 16'(code2);
    win(100);
    chk("held code", 16'(code2), d);
    chk("clock alive", 16'(r2 > 0), 16'h0001);
    // Second reset in mid-run must restore every field
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    reset_chk();
    conclude();
  end
endmodule : flrc_top_tb
